//--- tcc_pkg.sv
// Shared constants and types for the timer compare/capture unit
`default_nettype none
package tcc_pkg;
   // Register word indices (byte address is four times the index)
   localparam logic [8:0] IDX_RUN = 9'h180;
   localparam logic [8:0] IDX_MODE = 9'h182;
   localparam logic [8:0] IDX_FFCR = 9'h183;
   localparam logic [8:0] IDX_PINFN = 9'h184;
   localparam logic [8:0] IDX_CMPA_LO = 9'h188;
   localparam logic [8:0] IDX_CMPA_HI = 9'h189;
   localparam logic [8:0] IDX_CMPB_LO = 9'h18A;
   localparam logic [8:0] IDX_CMPB_HI = 9'h18B;
   localparam logic [8:0] IDX_CAPA_LO = 9'h18C;
   localparam logic [8:0] IDX_CAPA_HI = 9'h18D;
   localparam logic [8:0] IDX_CAPB_LO = 9'h18E;
   localparam logic [8:0] IDX_CAPB_HI = 9'h18F;
   // Run register fields
   localparam int RUN_DBUF_BIT = 7;
   localparam int RUN_PRUN_BIT = 2;
   localparam int RUN_CRUN_BIT = 0;
   localparam logic [7:0] RUN_ONES = 8'h32;
   // Mode register fields
   localparam int MODE_SOFT_BIT = 5;
   localparam int MODE_SEL_LSB = 3;
   localparam int MODE_CLE_BIT = 2;
   // Flip-flop control register fields
   localparam int FFCR_A_CMD_LSB = 0;
   localparam int FFCR_MA_EN_BIT = 2;
   localparam int FFCR_MB_EN_BIT = 3;
   localparam int FFCR_CAP_EN_BIT = 4;
   localparam int FFCR_B_CMD_LSB = 6;
   // Reset values and counter maximum
   localparam logic [7:0] MODE_RST = 8'h20;
   localparam logic [2:0] FFEN_RST = 3'h0;
   localparam logic [1:0] PINFN_RST = 2'h0;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;

   typedef enum logic [1:0] {
      FF_INV = 2'b00,
      FF_SET = 2'b01,
      FF_CLR = 2'b10,
      FF_HOLD = 2'b11
   } tcc_ffcmd_e;

   typedef enum logic [1:0] {
      CAP_OFF = 2'b00,
      CAP_IN0_BOTH = 2'b01,
      CAP_IN0_IN1 = 2'b10,
      CAP_TRIG_BOTH = 2'b11
   } tcc_capsel_e;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } tcc_bus_e;
endpackage : tcc_pkg
`default_nettype wire

//--- tcc_capture.sv
// One capture register with low-then-high read lock
`timescale 1ns/1ps
`default_nettype none
module tcc_capture
   import tcc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cap_evt,
   input wire logic [15:0] count,
   input wire logic rd_lo,
   input wire logic rd_hi,
   output logic [15:0] value,
   output logic latch
);
   logic [15:0] value_q, value_d;
   logic lock_q, lock_d;
   logic latch_q, latch_d;

   always_comb
   begin
      value_d = value_q;
      lock_d = lock_q;
      latch_d = 1'b0;
      if (cap_evt && !lock_q)
      begin
         value_d = count;
         latch_d = 1'b1;
      end
      if (rd_hi)
         lock_d = 1'b0;
      if (rd_lo)
         lock_d = 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         value_q <= 16'h0000;
         lock_q <= 1'b0;
         latch_q <= 1'b0;
      end
      else
      begin
         value_q <= value_d;
         lock_q <= lock_d;
         latch_q <= latch_d;
      end
   end

   assign value = value_q;
   assign latch = latch_q;

   a_capture_lock: assert property (@(posedge clk_sys) disable iff (rst)
      lock_q && !rd_hi |=> value_q == $past(value_q))
      else $error("capture changed while locked");
   a_capture_load: assert property (@(posedge clk_sys) disable iff (rst)
      cap_evt && !lock_q |=> value_q == $past(count) && latch_q)
      else $error("capture did not latch counter");
   c_capture_blocked: cover property (@(posedge clk_sys) disable iff (rst)
      cap_evt && lock_q);
endmodule : tcc_capture
`default_nettype wire

//--- tcc_toggle_ff.sv
// Timer output flip-flop with toggle source and software command
`timescale 1ns/1ps
`default_nettype none
module tcc_toggle_ff
   import tcc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic toggle,
   input wire logic cmd_wr,
   input wire logic [1:0] cmd,
   output logic q
);
   logic ff_q, ff_d;

   always_comb
   begin
      ff_d = ff_q;
      if (toggle)
         ff_d = !ff_q;
      if (cmd_wr)
      begin
         case (tcc_ffcmd_e'(cmd))
            FF_INV: ff_d = !ff_q;
            FF_SET: ff_d = 1'b1;
            FF_CLR: ff_d = 1'b0;
            default: ff_d = toggle ? !ff_q : ff_q;
         endcase
      end
   end

   // Level after reset is not promised to software; zero keeps simulation clean
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         ff_q <= 1'b0;
      else
         ff_q <= ff_d;
   end

   assign q = ff_q;

   a_invert_once: assert property (@(posedge clk_sys) disable iff (rst)
      toggle && cmd_wr && cmd == FF_INV |=> ff_q != $past(ff_q))
      else $error("double inversion not single");
   a_cmd_wins: assert property (@(posedge clk_sys) disable iff (rst)
      cmd_wr && (cmd == FF_SET || cmd == FF_CLR) |=> ff_q == $past(cmd == FF_SET))
      else $error("set or clear lost to toggle");
   c_toggle_seen: cover property (@(posedge clk_sys) disable iff (rst)
      toggle && !cmd_wr);
endmodule : tcc_toggle_ff
`default_nettype wire

//--- tcc_timer_unit.sv
// Compare, capture and output section of one 16-bit timer channel
// Functional notes
// - With buffering on, buffer goes to compare A when counter meets compare B.
// - Two byte-written flags; copy happens on match only when both are set.
// - A copy clears both flags; a flag stays set until a copy occurs.
// - Reset clears buffer enable; software writes compare, enables, then buffer.
// - Compare A and buffer share addresses; buffering on writes buffer only.
// - Compare registers are write-only; reads return zero.
// - Each capture register latches the full counter on its event.
// - Between low and high byte reads, captures into that register are blocked.
// - Capture registers are read-only; writes do nothing.
// - Two-bit field picks capture timing and external interrupt edge.
// - Writing zero to soft capture bit loads counter into capture A.
// - Two comparators match counter with compare A and B, each raising interrupt.
// - Output flip-flops toggle on matches and capture latches, each gated.
// - Command 00 inverts, 01 sets, 10 clears the flip-flop.
// - Match toggle with software invert in one cycle inverts once.
// - Software set or clear wins over a coinciding match toggle.
// - Flip-flops drive output pins when pin function selects timer output.
// - With match clearing, counter returns to zero on compare B.
// - Comparator stays idle after a low-byte-only compare write, except compare A with buffering on.
// - Counter wrap past maximum raises the overflow interrupt.
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_unit
   import tcc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [10:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic count_tick,
   input wire logic cap_in0,
   input wire logic cap_in1,
   input wire logic cap_trig,
   output logic match_a_irq,
   output logic match_b_irq,
   output logic overflow_irq,
   output logic ext_irq,
   output logic timer_out_a,
   output logic timer_out_b
);
   function automatic logic hit(input logic [10:0] addr, input logic [8:0] idx);
      hit = (addr[10:2] == idx);
   endfunction : hit

   tcc_bus_e st_q, st_d;
   logic [31:0] rdata_q, rdata_d;
   logic wait_q, wait_d;
   logic dbuf_enable_q, dbuf_enable_d, prescaler_run_q, prescaler_run_d;
   logic counter_run_ctrl_q, counter_run_ctrl_d;
   logic [7:0] timer_mode_reg_q, timer_mode_reg_d;
   logic [2:0] ffen_q, ffen_d;
   logic [1:0] pinfn_q, pinfn_d;
   logic [15:0] compare_reg_a_q, compare_reg_a_d, compare_reg_b_q, compare_reg_b_d;
   logic [15:0] buf_q, buf_d;
   logic flag_lo_q, flag_lo_d, flag_hi_q, flag_hi_d;
   logic act_a_q, act_a_d, act_b_q, act_b_d;
   logic [15:0] up_counter_q, up_counter_d;
   logic mat_a_q, mat_a_d, mat_b_q, mat_b_d, ovf_q, ovf_d, ext_q, ext_d;
   logic out_a_q, out_a_d, out_b_q, out_b_d;
   logic [2:0] s1_q, s2_q, s3_q;
   logic wr_ev, rd_ev, tick_ok, clear_hit, copy, soft_cap;
   logic in0_rise, in0_fall, in1_rise, trig_rise, trig_fall;
   logic [1:0] cap_evt, cap_lo, cap_hi, cap_latch, ff_tog, ff_wr, ff_state;
   logic [1:0] ff_cmd [2];
   logic [15:0] cap_val [2];
   logic [7:0] wd;

   // Pins are asynchronous: two flops, then a third stage for edges
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
         s3_q <= 3'h0;
      end
      else
      begin
         s1_q <= {cap_trig, cap_in1, cap_in0};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_comb
   begin
      wd = avs_writedata[7:0];
      wr_ev = (st_q == BUS_ACK) && avs_write && avs_byteenable[0];
      rd_ev = (st_q == BUS_ACK) && avs_read;
      in0_rise = s2_q[0] && !s3_q[0];
      in0_fall = !s2_q[0] && s3_q[0];
      in1_rise = s2_q[1] && !s3_q[1];
      trig_rise = s2_q[2] && !s3_q[2];
      trig_fall = !s2_q[2] && s3_q[2];
      soft_cap = wr_ev && hit(avs_address, IDX_MODE) && !wd[MODE_SOFT_BIT];
      cap_evt = 2'b00;
      ext_d = in0_rise;
      case (tcc_capsel_e'(timer_mode_reg_q[MODE_SEL_LSB +: 2]))
         CAP_IN0_BOTH:
         begin
            cap_evt = {in0_fall, in0_rise};
            ext_d = in0_fall;
         end
         CAP_IN0_IN1: cap_evt = {in1_rise, in0_rise};
         CAP_TRIG_BOTH: cap_evt = {trig_fall, trig_rise};
         default: cap_evt = 2'b00;
      endcase
      cap_evt[0] = cap_evt[0] || soft_cap;
      cap_lo[0] = rd_ev && hit(avs_address, IDX_CAPA_LO);
      cap_hi[0] = rd_ev && hit(avs_address, IDX_CAPA_HI);
      cap_lo[1] = rd_ev && hit(avs_address, IDX_CAPB_LO);
      cap_hi[1] = rd_ev && hit(avs_address, IDX_CAPB_HI);
   end

   // Bus: request seen, then one cycle with waitrequest low
   always_comb
   begin
      st_d = st_q;
      rdata_d = rdata_q;
      case (st_q)
         BUS_IDLE:
         begin
            if (avs_read || avs_write)
               st_d = BUS_ACK;
            rdata_d = 32'h0000_0000;
            if (hit(avs_address, IDX_RUN))
               rdata_d[7:0] = RUN_ONES | {dbuf_enable_q, 4'h0, prescaler_run_q, 1'b0,
                  counter_run_ctrl_q};
            if (hit(avs_address, IDX_MODE))
               rdata_d[7:0] = timer_mode_reg_q | (8'h01 << MODE_SOFT_BIT);
            if (hit(avs_address, IDX_FFCR))
               rdata_d[7:0] = {FF_HOLD, 1'b0, ffen_q, FF_HOLD};
            if (hit(avs_address, IDX_PINFN))
               rdata_d[7:0] = {6'h00, pinfn_q};
            if (hit(avs_address, IDX_CAPA_LO))
               rdata_d[7:0] = cap_val[0][7:0];
            if (hit(avs_address, IDX_CAPA_HI))
               rdata_d[7:0] = cap_val[0][15:8];
            if (hit(avs_address, IDX_CAPB_LO))
               rdata_d[7:0] = cap_val[1][7:0];
            if (hit(avs_address, IDX_CAPB_HI))
               rdata_d[7:0] = cap_val[1][15:8];
         end
         BUS_ACK: st_d = BUS_IDLE;
         default: st_d = BUS_IDLE;
      endcase
      wait_d = (st_d != BUS_ACK);
   end

   // Control, compare, counter and event logic
   always_comb
   begin
      dbuf_enable_d = dbuf_enable_q;
      prescaler_run_d = prescaler_run_q;
      counter_run_ctrl_d = counter_run_ctrl_q;
      timer_mode_reg_d = timer_mode_reg_q;
      ffen_d = ffen_q;
      pinfn_d = pinfn_q;
      compare_reg_a_d = compare_reg_a_q;
      compare_reg_b_d = compare_reg_b_q;
      buf_d = buf_q;
      flag_lo_d = flag_lo_q;
      flag_hi_d = flag_hi_q;
      act_a_d = act_a_q;
      act_b_d = act_b_q;
      up_counter_d = up_counter_q;
      tick_ok = counter_run_ctrl_q && prescaler_run_q && count_tick;
      clear_hit = timer_mode_reg_q[MODE_CLE_BIT] && (up_counter_q == compare_reg_b_q);
      if (!counter_run_ctrl_q)
         up_counter_d = 16'h0000;
      else if (tick_ok)
         up_counter_d = clear_hit ? 16'h0000 : up_counter_q + 16'h0001;
      ovf_d = tick_ok && !clear_hit && (up_counter_q == CNT_MAX);
      mat_a_d = tick_ok && act_a_q && (up_counter_d == compare_reg_a_q);
      mat_b_d = tick_ok && act_b_q && (up_counter_d == compare_reg_b_q);
      copy = mat_b_d && dbuf_enable_q && flag_lo_q && flag_hi_q;
      if (copy)
      begin
         compare_reg_a_d = buf_q;
         act_a_d = 1'b1;
         flag_lo_d = 1'b0;
         flag_hi_d = 1'b0;
      end
      if (wr_ev)
      begin
         if (hit(avs_address, IDX_RUN))
         begin
            dbuf_enable_d = wd[RUN_DBUF_BIT];
            prescaler_run_d = wd[RUN_PRUN_BIT];
            counter_run_ctrl_d = wd[RUN_CRUN_BIT];
         end
         if (hit(avs_address, IDX_MODE))
            timer_mode_reg_d = wd;
         if (hit(avs_address, IDX_FFCR))
            ffen_d = wd[FFCR_MA_EN_BIT +: 3];
         if (hit(avs_address, IDX_PINFN))
            pinfn_d = wd[1:0];
         // A byte write sets its flag even if a copy clears in the same cycle
         if (hit(avs_address, IDX_CMPA_LO))
         begin
            buf_d[7:0] = wd;
            flag_lo_d = 1'b1;
            if (!dbuf_enable_q)
            begin
               compare_reg_a_d[7:0] = wd;
               act_a_d = 1'b0;
            end
         end
         if (hit(avs_address, IDX_CMPA_HI))
         begin
            buf_d[15:8] = wd;
            flag_hi_d = 1'b1;
            if (!dbuf_enable_q)
            begin
               compare_reg_a_d[15:8] = wd;
               act_a_d = 1'b1;
            end
         end
         if (hit(avs_address, IDX_CMPB_LO))
         begin
            compare_reg_b_d[7:0] = wd;
            act_b_d = 1'b0;
         end
         if (hit(avs_address, IDX_CMPB_HI))
         begin
            compare_reg_b_d[15:8] = wd;
            act_b_d = 1'b1;
         end
      end
      ff_wr[0] = wr_ev && hit(avs_address, IDX_FFCR);
      ff_wr[1] = ff_wr[0];
      ff_cmd[0] = wd[FFCR_A_CMD_LSB +: 2];
      ff_cmd[1] = wd[FFCR_B_CMD_LSB +: 2];
      // Enable changes while counting are racy; software stops the timer first
      ff_tog[0] = (mat_a_q && ffen_q[0]) || (cap_latch[0] && ffen_q[2]);
      ff_tog[1] = (mat_b_q && ffen_q[1]) || (cap_latch[1] && ffen_q[2]);
      out_a_d = pinfn_q[0] && ff_state[0];
      out_b_d = pinfn_q[1] && ff_state[1];
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         st_q <= BUS_IDLE;
         rdata_q <= 32'h0000_0000;
         wait_q <= 1'b1;
         dbuf_enable_q <= 1'b0;
         prescaler_run_q <= 1'b0;
         counter_run_ctrl_q <= 1'b0;
         timer_mode_reg_q <= MODE_RST;
         ffen_q <= FFEN_RST;
         pinfn_q <= PINFN_RST;
         compare_reg_a_q <= 16'h0000;
         compare_reg_b_q <= 16'h0000;
         buf_q <= 16'h0000;
         flag_lo_q <= 1'b0;
         flag_hi_q <= 1'b0;
         act_a_q <= 1'b0;
         act_b_q <= 1'b0;
         up_counter_q <= 16'h0000;
         mat_a_q <= 1'b0;
         mat_b_q <= 1'b0;
         ovf_q <= 1'b0;
         ext_q <= 1'b0;
         out_a_q <= 1'b0;
         out_b_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         rdata_q <= rdata_d;
         wait_q <= wait_d;
         dbuf_enable_q <= dbuf_enable_d;
         prescaler_run_q <= prescaler_run_d;
         counter_run_ctrl_q <= counter_run_ctrl_d;
         timer_mode_reg_q <= timer_mode_reg_d;
         ffen_q <= ffen_d;
         pinfn_q <= pinfn_d;
         compare_reg_a_q <= compare_reg_a_d;
         compare_reg_b_q <= compare_reg_b_d;
         buf_q <= buf_d;
         flag_lo_q <= flag_lo_d;
         flag_hi_q <= flag_hi_d;
         act_a_q <= act_a_d;
         act_b_q <= act_b_d;
         up_counter_q <= up_counter_d;
         mat_a_q <= mat_a_d;
         mat_b_q <= mat_b_d;
         ovf_q <= ovf_d;
         ext_q <= ext_d;
         out_a_q <= out_a_d;
         out_b_q <= out_b_d;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_chan
         tcc_capture u_cap (
            .clk_sys(clk_sys),
            .rst(rst),
            .cap_evt(cap_evt[gi]),
            .count(up_counter_q),
            .rd_lo(cap_lo[gi]),
            .rd_hi(cap_hi[gi]),
            .value(cap_val[gi]),
            .latch(cap_latch[gi])
         );
         tcc_toggle_ff u_ff (
            .clk_sys(clk_sys),
            .rst(rst),
            .toggle(ff_tog[gi]),
            .cmd_wr(ff_wr[gi]),
            .cmd(ff_cmd[gi]),
            .q(ff_state[gi])
         );
      end
   endgenerate

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign match_a_irq = mat_a_q;
   assign match_b_irq = mat_b_q;
   assign overflow_irq = ovf_q;
   assign ext_irq = ext_q;
   assign timer_out_a = out_a_q;
   assign timer_out_b = out_b_q;

   a_dbuf_copy: assert property (@(posedge clk_sys) disable iff (rst)
      copy |=> compare_reg_a_q == $past(buf_q) && match_b_irq)
      else $error("buffer not copied on compare B match");
   a_copy_needs_flags: assert property (@(posedge clk_sys) disable iff (rst)
      $changed(compare_reg_a_q) && $past(dbuf_enable_q) |-> $past(flag_lo_q && flag_hi_q))
      else $error("copy without both byte flags");
   a_copy_clears: assert property (@(posedge clk_sys) disable iff (rst)
      copy && !wr_ev |=> !flag_lo_q && !flag_hi_q)
      else $error("flags not cleared by copy");
   a_reset_state: assert property (@(posedge clk_sys)
      $past(rst) |-> !dbuf_enable_q && !flag_lo_q && !flag_hi_q)
      else $error("buffer state not cleared by reset");
   a_buffered_write: assert property (@(posedge clk_sys) disable iff (rst)
      wr_ev && dbuf_enable_q && hit(avs_address, IDX_CMPA_LO) && !copy
      |=> $stable(compare_reg_a_q) && buf_q[7:0] == $past(wd))
      else $error("buffered write reached compare A");
   a_compare_wo: assert property (@(posedge clk_sys) disable iff (rst)
      !avs_waitrequest && avs_read && avs_address[10:4] == IDX_CMPA_LO[8:2]
      && !avs_address[4 - 1 - 1 + 1] |-> avs_readdata == 32'h0000_0000)
      else $error("compare register readable");
   a_soft_capture: assert property (@(posedge clk_sys) disable iff (rst)
      soft_cap && !(cap_hi[0]) ##1 !$past(g_chan[0].u_cap.lock_q)
      |-> cap_val[0] == $past(up_counter_q))
      else $error("soft capture missed");
   a_match_clear: assert property (@(posedge clk_sys) disable iff (rst)
      tick_ok && clear_hit |=> up_counter_q == 16'h0000)
      else $error("counter not cleared on compare B");
   a_overflow: assert property (@(posedge clk_sys) disable iff (rst)
      tick_ok && !clear_hit && up_counter_q == CNT_MAX |=> overflow_irq && up_counter_q == 16'h0000)
      else $error("overflow not flagged");
   a_out_pin: assert property (@(posedge clk_sys) disable iff (rst)
      pinfn_q[0] && $stable(pinfn_q) |=> timer_out_a == $past(ff_state[0]))
      else $error("timer output pin not following flip-flop");
   c_dbuf_copy: cover property (@(posedge clk_sys) disable iff (rst) copy);
   c_overflow: cover property (@(posedge clk_sys) disable iff (rst) overflow_irq);
   c_match_a: cover property (@(posedge clk_sys) disable iff (rst) match_a_irq ##1 timer_out_a);
endmodule : tcc_timer_unit
`default_nettype wire

//--- test_tcc_timer_unit.sv
// Self-checking bench for the timer compare/capture unit
`timescale 1ns/1ps
`default_nettype none
module test_tcc_timer_unit
   import tcc_pkg::*;
;
   logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, count_tick;
   logic cap_in0, cap_in1, cap_trig, match_a_irq, match_b_irq, overflow_irq, ext_irq;
   logic timer_out_a, timer_out_b, ea, eb;
   logic [10:0] avs_address;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, lfsr;
   logic [31:0] exp_q[$];
   logic [1:0] cmd_a[3] = '{2'b01, 2'b10, 2'b00};
   logic [1:0] cmd_b[3] = '{2'b10, 2'b01, 2'b00};
   int failures, checks, na, nb, ne, nov, i;

   tcc_timer_unit dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .count_tick(count_tick), .cap_in0(cap_in0),
      .cap_in1(cap_in1), .cap_trig(cap_trig), .match_a_irq(match_a_irq),
      .match_b_irq(match_b_irq), .overflow_irq(overflow_irq), .ext_irq(ext_irq),
      .timer_out_a(timer_out_a), .timer_out_b(timer_out_b));

   always #10 clk_sys = ~clk_sys;

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   function automatic logic ff_apply(input logic q, input logic [1:0] c);
      return (c == 2'b00) ? !q : (c == 2'b01) ? 1'b1 : (c == 2'b10) ? 1'b0 : q;
   endfunction : ff_apply

   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      checks++;
      if (seen !== expv)
      begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, expv);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   // Request held until waitrequest is sampled low; an edge passes before each one
   task automatic bus(input logic wr, input logic [8:0] idx, input logic [7:0] d,
                      input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && n < 100)
      begin
         n++;
         @(posedge clk_sys);
      end
      if (n == 100)
         failures++;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic wr(input logic [8:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d, 4'hF);
   endtask : wr

   task automatic rd(input logic [8:0] idx, input logic [7:0] e);
      exp_q.push_back({24'h0, e});
      bus(1'b0, idx, 8'h00, 4'hF);
   endtask : rd

   // Random gaps of one to four idle cycles keep ticks from merging
   task automatic tick(input int n);
      for (int k = 0; k < n; k++)
      begin
         lfsr = lfsr_next(lfsr);
         count_tick <= 1'b1;
         @(posedge clk_sys);
         count_tick <= 1'b0;
         repeat ({1'b0, lfsr[1:0]} + 3'd1) @(posedge clk_sys);
      end
   endtask : tick

   always @(posedge clk_sys)
   begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
         check(avs_readdata, exp_q.pop_front());
      if (match_a_irq === 1'b1)
         na++;
      if (match_b_irq === 1'b1)
         nb++;
      if (ext_irq === 1'b1)
         ne++;
      if (overflow_irq === 1'b1)
         nov++;
   end

   initial
   begin
      #1_000_000;
      failures++;
      print_verdict();
   end

   initial
   begin
      clk_sys = 1'b0;
      rst = 1'b1;
      {avs_read, avs_write, count_tick, cap_in0, cap_in1, cap_trig} = '0;
      avs_address = '0;
      avs_byteenable = 4'hF;
      avs_writedata = '0;
      lfsr = 32'h8EE5F191;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      rd(IDX_RUN, 8'h32);
      rd(IDX_MODE, 8'h20);
      rd(IDX_FFCR, 8'hC3);
      rd(9'h190, 8'h00);
      wr(IDX_RUN, 8'h05);
      tick(300);
      wr(IDX_MODE, 8'h00);
      rd(IDX_CAPA_LO, 8'h2C);
      tick(300);
      wr(IDX_MODE, 8'h00);
      rd(IDX_CAPA_HI, 8'h01);
      wr(IDX_MODE, 8'h00);
      wr(IDX_CAPA_LO, 8'hFF);
      rd(IDX_CAPA_LO, 8'h58);
      rd(IDX_CAPA_HI, 8'h02);
      wr(IDX_CMPA_LO, 8'h60);
      wr(IDX_CMPB_LO, 8'h64);
      wr(IDX_CMPB_HI, 8'h02);
      tick(20);
      repeat (2) @(posedge clk_sys);
      check(na, 0);
      check(nb, 1);
      wr(IDX_CMPA_HI, 8'h02);
      rd(IDX_CMPA_LO, 8'h00);
      wr(IDX_RUN, 8'h04);
      wr(IDX_MODE, 8'h24);
      wr(IDX_PINFN, 8'h03);
      ea = 1'b0;
      eb = 1'b0;
      for (i = 0; i < 3; i++)
      begin
         wr(IDX_FFCR, {cmd_b[i], 4'h0, cmd_a[i]});
         ea = ff_apply(ea, cmd_a[i]);
         eb = ff_apply(eb, cmd_b[i]);
         repeat (3) @(posedge clk_sys);
         check({31'h0, timer_out_a}, {31'h0, ea});
         check({31'h0, timer_out_b}, {31'h0, eb});
      end
      wr(IDX_FFCR, 8'hCF);
      rd(IDX_FFCR, 8'hCF);
      wr(IDX_RUN, 8'h05);
      tick(613);
      repeat (3) @(posedge clk_sys);
      check(na, 1);
      check(nb, 2);
      check({31'h0, timer_out_a}, {31'h0, !ea});
      check({31'h0, timer_out_b}, {31'h0, !eb});
      wr(IDX_RUN, 8'h85);
      bus(1'b1, IDX_RUN, 8'h00, 4'hE);
      rd(IDX_RUN, 8'hB7);
      wr(IDX_CMPA_LO, 8'h10);
      wr(IDX_CMPA_HI, 8'h00);
      tick(20);
      repeat (2) @(posedge clk_sys);
      check(na, 1);
      tick(593);
      tick(20);
      repeat (2) @(posedge clk_sys);
      check(na, 3);
      wr(IDX_MODE, 8'h2C);
      cap_in0 <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rd(IDX_CAPA_LO, 8'h14);
      rd(IDX_CAPA_HI, 8'h00);
      tick(5);
      cap_in0 <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rd(IDX_CAPB_LO, 8'h19);
      rd(IDX_CAPB_HI, 8'h00);
      check(ne, 1);
      check(nov, 0);
      repeat (4) @(posedge clk_sys);
      print_verdict();
   end
endmodule : test_tcc_timer_unit
`default_nettype wire
